// [rtl/pvg_pkg.sv]
// Purpose: constants for the input turn-off threshold and current-sense gain registers
// Assumes: words arrive already framed by the PMBus command decoder
// Notes: linear format, exponent in bits 15:11 of the word
package pvg_pkg;
  localparam logic [7:0]  PVG_CMD_INPUT_TURN_OFF_THRESHOLD_THR  = 8'h36;
  localparam logic [7:0]  PVG_CMD_CS_GAIN      = 8'h38;
  localparam logic [4:0]  PVG_THR_EXP          = 5'h1E;
  localparam logic [4:0]  PVG_GAIN_EXP         = 5'h10;
  localparam logic [10:0] PVG_THR_MANT_RST     = 11'h010;
  localparam logic [10:0] PVG_THR_MANT_MIN     = 11'h010;
  localparam logic [10:0] PVG_THR_MANT_MAX     = 11'h03F;
  localparam logic [10:0] PVG_THR_FINE_MAX     = 11'h025;
  localparam logic [10:0] PVG_THR_MID_MAX      = 11'h033;
  localparam logic [10:0] PVG_GAIN_MANT_RST    = 11'h020;
  localparam logic [10:0] PVG_GAIN_MANT_MIN    = 11'h010;
  localparam logic [10:0] PVG_GAIN_MANT_MAX    = 11'h1FC;
  localparam int          PVG_EXP_LSB          = 11;
  localparam logic [7:0]  PVG_PAGE_CH1         = 8'h00;
  localparam logic [7:0]  PVG_PAGE_CH2         = 8'h01;
  localparam logic [7:0]  PVG_PAGE_BOTH        = 8'hFF;
  typedef enum logic [1:0] {PVG_IDLE = 2'b00, PVG_LOAD = 2'b01} pvg_state_t;
endpackage

// [rtl/pvg_regs.sv]
// Purpose: storage and write checking of the input turn-off threshold and per-channel current-sense gain
// Assumes: one-cycle write/read strobes from a PMBus front end; turn-on threshold supplied as a word
// Notes: user defaults are taken over in one load cycle after reset
`timescale 1ns/1ps
// Contract
// [RULE1] An in-range threshold is snapped to the nearest supported step before it is stored.
// [RULE2] An out-of-range threshold write flags the communication and invalid-data bits and raises alert.
// [RULE3] A rejected threshold write leaves the stored threshold unchanged.
// [RULE4] A threshold equal to or above the turn-on threshold is refused as out of range.
// [RULE5] The threshold resets to exponent minus two and mantissa 16, meaning 4 V.
// [RULE6] Only threshold mantissas 16 to 63 are accepted.
// [RULE7] The exponent field of both registers is read-only and written values there are dropped.
// [RULE8] The gain register carries the fixed exponent 10000, a 15.26 micro-ohm step.
// [RULE9] The gain mantissa resets to 32.
// [RULE10] The gain mantissa is limited to 16 through 508.
// [RULE11] Page 00 picks channel one, 01 channel two and 11 both channels for the gain; the code takes page FF for both.
// [RULE12] Channel one always takes gain writes, channel two only as master, a slave mirrors channel one; the code refuses a both-page write as slave.
// [RULE13] A channel-two gain write while slave is NACKed, flags an invalid command and raises alert.
// [RULE14] Stacked second devices must be given the master gain by the host, which hardware does not check.
// [RULE15] User-saved values may replace the factory defaults at start-up.
// [RULE16] A value is its two's-complement mantissa times two to the exponent.
// [RULE17] Each register moves as a 16-bit word with exponent in the high byte.
module pvg_regs
  import pvg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] wr_word,
  input  wire logic [7:0]  page,
  input  wire logic        ch2_master,
  input  wire logic [15:0] input_turn_on_threshold,
  input  wire logic        user_load,
  input  wire logic [10:0] user_thr_mant,
  input  wire logic [10:0] user_gain1_mant,
  input  wire logic [10:0] user_gain2_mant,
  input  wire logic        status_clr,
  output logic      [15:0] rd_word,
  output logic             rd_valid,
  output logic             nack,
  output logic             cml_flag,
  output logic             invalid_data,
  output logic             invalid_command_fault,
  output logic             smb_alert_n,
  output logic      [15:0] thr_word,
  output logic      [15:0] gain1_word,
  output logic      [15:0] gain2_word
);
  logic [10:0] thr_reg, thr_next;
  logic [10:0] gain_reg [2];
  logic [10:0] gain_next [2];
  logic        user_done_reg, user_done_next;
  logic [15:0] rd_word_reg, rd_word_next;
  logic        rd_valid_reg, rd_valid_next;
  logic        nack_reg, nack_next;
  logic        cml_reg, cml_next;
  logic        ivd_reg, ivd_next;
  logic        ivc_reg, ivc_next;
  logic [10:0] wr_mant;
  logic [10:0] on_mant;
  logic        thr_ok;
  logic        gain_ok;
  logic        sel_ch1;
  logic        sel_ch2;
  logic        ch2_blocked;
  logic [10:0] thr_over;
  logic [10:0] thr_snap;

  // Exponent bits of the incoming word are never looked at
  assign wr_mant = wr_word[PVG_EXP_LSB-1:0]; // [RULE7] [RULE17]
  // Turn-on word shares the quarter-volt exponent, so mantissas compare directly
  assign on_mant = input_turn_on_threshold[PVG_EXP_LSB-1:0]; // [RULE16]
  // Range check uses the written mantissa; snapping raises 54, 58 and 62 by one, so a stored value can reach the turn-on value
  assign thr_ok  = !wr_mant[10] && wr_mant >= PVG_THR_MANT_MIN && wr_mant <= PVG_THR_MANT_MAX // [RULE6] [RULE1]
                   && wr_mant < on_mant; // [RULE4]
  assign gain_ok = !wr_mant[10] && wr_mant >= PVG_GAIN_MANT_MIN && wr_mant <= PVG_GAIN_MANT_MAX; // [RULE10]
  assign sel_ch1 = page == PVG_PAGE_CH1 || page == PVG_PAGE_BOTH; // [RULE11]
  assign sel_ch2 = page == PVG_PAGE_CH2 || page == PVG_PAGE_BOTH; // [RULE11]
  assign ch2_blocked = sel_ch2 && !ch2_master; // [RULE12]

  // Supported steps: every count up to 37, odd counts up to 51, then every fourth count to 63
  // Ties go to the lower step, but 54, 58 and 62 snap up by one towards the turn-on value
  always_comb
  begin
    thr_over = wr_mant - PVG_THR_MID_MAX;
    if (wr_mant <= PVG_THR_FINE_MAX)
      thr_snap = wr_mant; // [RULE1]
    else if (wr_mant <= PVG_THR_MID_MAX)
      thr_snap = wr_mant[0] ? wr_mant : wr_mant - 11'h001; // [RULE1]
    else
      thr_snap = PVG_THR_MID_MAX + {thr_over[10:2], 2'b00}
                 + ((thr_over[1:0] == 2'b11) ? 11'h004 : 11'h000); // [RULE1]
  end

  always_comb
  begin
    thr_next       = thr_reg;
    gain_next[0]   = gain_reg[0];
    gain_next[1]   = gain_reg[1];
    user_done_next = 1'b1;
    rd_word_next   = rd_word_reg;
    rd_valid_next  = 1'b0;
    nack_next      = 1'b0;
    cml_next       = cml_reg;
    ivd_next       = ivd_reg;
    ivc_next       = ivc_reg;
    if (status_clr)
    begin
      cml_next = 1'b0;
      ivd_next = 1'b0;
      ivc_next = 1'b0;
    end
    if (!user_done_reg && user_load)
    begin
      thr_next     = user_thr_mant; // [RULE15]
      gain_next[0] = user_gain1_mant; // [RULE15]
      gain_next[1] = user_gain2_mant; // [RULE15]
    end
    else if (wr_stb && cmd_code == PVG_CMD_INPUT_TURN_OFF_THRESHOLD_THR)
    begin
      if (thr_ok)
        thr_next = thr_snap; // [RULE1]
      else
      begin
        // Stored value kept; set beats a same-cycle clear
        cml_next = 1'b1; // [RULE2] [RULE3]
        ivd_next = 1'b1; // [RULE2]
      end
    end
    else if (wr_stb && cmd_code == PVG_CMD_CS_GAIN)
    begin
      if (ch2_blocked)
      begin
        // Whole command refused, even the channel-one half of a both-page write
        nack_next = 1'b1; // [RULE13]
        cml_next  = 1'b1; // [RULE13]
        ivc_next  = 1'b1; // [RULE13]
      end
      else if (!gain_ok)
      begin
        cml_next = 1'b1;
        ivd_next = 1'b1;
      end
      else
      begin
        if (sel_ch1)
          gain_next[0] = wr_mant; // [RULE12]
        if (sel_ch2)
          gain_next[1] = wr_mant; // [RULE12]
      end
    end
    if (rd_stb)
    begin
      rd_valid_next = 1'b1;
      case (cmd_code)
        PVG_CMD_INPUT_TURN_OFF_THRESHOLD_THR: rd_word_next = {PVG_THR_EXP, thr_reg}; // [RULE17]
        PVG_CMD_CS_GAIN:     rd_word_next = (page == PVG_PAGE_CH2)
                                            ? {PVG_GAIN_EXP, ch2_master ? gain_reg[1] : gain_reg[0]}
                                            : {PVG_GAIN_EXP, gain_reg[0]}; // [RULE8]
        default:             rd_word_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      thr_reg       <= PVG_THR_MANT_RST; // [RULE5]
      gain_reg[0]   <= PVG_GAIN_MANT_RST; // [RULE9]
      gain_reg[1]   <= PVG_GAIN_MANT_RST; // [RULE9]
      user_done_reg <= 1'b0;
      rd_word_reg   <= 16'h0000;
      rd_valid_reg  <= 1'b0;
      nack_reg      <= 1'b0;
      cml_reg       <= 1'b0;
      ivd_reg       <= 1'b0;
      ivc_reg       <= 1'b0;
    end
    else
    begin
      thr_reg       <= thr_next;
      gain_reg[0]   <= gain_next[0];
      gain_reg[1]   <= gain_next[1];
      user_done_reg <= user_done_next;
      rd_word_reg   <= rd_word_next;
      rd_valid_reg  <= rd_valid_next;
      nack_reg      <= nack_next;
      cml_reg       <= cml_next;
      ivd_reg       <= ivd_next;
      ivc_reg       <= ivc_next;
    end
  end

  // Registered copies so every output leaves a flip-flop
  logic [15:0] gain2_out_reg;
  logic        alert_n_reg;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gain2_out_reg <= {PVG_GAIN_EXP, PVG_GAIN_MANT_RST};
      alert_n_reg   <= 1'b1;
    end
    else
    begin
      gain2_out_reg <= {PVG_GAIN_EXP, ch2_master ? gain_next[1] : gain_next[0]}; // [RULE12]
      alert_n_reg   <= !(cml_next || ivc_next); // [RULE2] [RULE13]
    end
  end

  assign rd_word               = rd_word_reg;
  assign rd_valid              = rd_valid_reg;
  assign nack                  = nack_reg;
  assign cml_flag              = cml_reg;
  assign invalid_data          = ivd_reg;
  assign invalid_command_fault = ivc_reg;
  assign smb_alert_n           = alert_n_reg;
  assign thr_word              = {PVG_THR_EXP, thr_reg};
  assign gain1_word            = {PVG_GAIN_EXP, gain_reg[0]};
  assign gain2_word            = gain2_out_reg;
endmodule

// [tb/pvg_regs_checker.sv]
// Purpose: port checks for pvg_regs
// Assumes: user defaults are in range
// Notes: bound below
`timescale 1ns/1ps
module pvg_regs_checker
  import pvg_pkg::*;
(
  input wire logic        clk, nrst, wr_stb, rd_stb, ch2_master, rd_valid, nack,
  input wire logic        cml_flag, invalid_data, invalid_command_fault, smb_alert_n,
  input wire logic [7:0]  cmd_code, page,
  input wire logic [15:0] wr_word, input_turn_on_threshold, thr_word, gain1_word, gain2_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [10:0] mt;
  logic        thr_bad, gain_wr;
  assign mt      = wr_word[10:0];
  assign thr_bad = mt < PVG_THR_MANT_MIN || mt > PVG_THR_MANT_MAX || mt >= input_turn_on_threshold[10:0];
  assign gain_wr = wr_stb && cmd_code == PVG_CMD_CS_GAIN;
  sequence s_thr_wr; wr_stb && cmd_code == PVG_CMD_INPUT_TURN_OFF_THRESHOLD_THR; endsequence
  sequence s_fault; cml_flag && !smb_alert_n; endsequence
  AST_THR_BAD: assert property (s_thr_wr ##0 thr_bad |=> s_fault ##0 invalid_data && $stable(thr_word))
    else $error("bad threshold not refused");
  // Above mantissa 37 the steps widen, so only the uniform part up to 37 is checked as stored as written
  AST_THR_OK: assert property (s_thr_wr ##0 !thr_bad && mt <= 11'h025 |=> thr_word == {PVG_THR_EXP, $past(mt)})
    else $error("threshold not stored");
  AST_EXP: assert property (thr_word[15:11] == PVG_THR_EXP && gain1_word[15:11] == PVG_GAIN_EXP)
    else $error("exponent changed");
  AST_THR_LIM: assert property (thr_word[10:0] >= PVG_THR_MANT_MIN && thr_word[10:0] <= PVG_THR_MANT_MAX)
    else $error("threshold out of range");
  AST_GAIN_BAD: assert property (gain_wr && page == 8'h00 && mt > PVG_GAIN_MANT_MAX |=> s_fault ##0 $stable(gain1_word))
    else $error("bad gain not refused");
  AST_CH1: assert property (gain_wr && page == 8'h00 && mt >= PVG_GAIN_MANT_MIN && mt <= PVG_GAIN_MANT_MAX
    |=> gain1_word[10:0] == $past(mt)) else $error("gain not stored");
  AST_SLAVE: assert property (gain_wr && page == 8'h01 && !ch2_master |=> nack && invalid_command_fault ##0 s_fault)
    else $error("slave write not refused");
  AST_MIRROR: assert property ((!ch2_master && $stable(gain1_word))[*2] |-> gain2_word == gain1_word)
    else $error("slave gain not mirrored");
  AST_RD: assert property (rd_stb |=> rd_valid)
    else $error("read not answered");
endmodule
bind pvg_regs pvg_regs_checker chk_u (.*);

// [tb/pvg_host.sv]
// Purpose: bus host model issuing word reads and writes
// Assumes: one request at a time
// Notes: released command and data lines show the inverted last value; strobes drop to 0 and page holds
`timescale 1ns/1ps
module pvg_host
(
  input  wire logic        clk,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic      [7:0]  cmd_code,
  output logic      [7:0]  page,
  output logic      [15:0] wr_word
);
  initial {wr_stb, rd_stb, cmd_code, page, wr_word} = '0;
  // Gap adds idle cycles so the host can issue a request late as well as at once
  task automatic xfer(input logic wr, input logic [7:0] c, p, input logic [15:0] w, input int gap);
    repeat (gap + 1) @(posedge clk);
    #1 {wr_stb, rd_stb, cmd_code, page, wr_word} = {wr, !wr, c, p, w};
    @(posedge clk);
    #1 {wr_stb, rd_stb, cmd_code, wr_word} = {2'b00, ~c, ~w};
  endtask
endmodule

// [tb/tb_pvg_regs.sv]
// Purpose: self-checking bench for pvg_regs
// Assumes: host model issues all requests
// Notes: reads are queued and checked by a monitor
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_pvg_regs;
  import pvg_pkg::*;
  localparam logic [7:0] TH = PVG_CMD_INPUT_TURN_OFF_THRESHOLD_THR, GN = PVG_CMD_CS_GAIN;
  logic        clk = 0, nrst = 0, ch2_master = 1, user_load = 0, status_clr = 0;
  logic [15:0] input_turn_on_threshold = 16'hF040, exp_v, wr_word, rd_word, thr_word, gain1_word, gain2_word;
  logic [10:0] m, user_thr_mant = 11'h014, user_gain1_mant = 11'h028, user_gain2_mant = 11'h03C;
  logic [10:0] bad[3] = '{11'h00F, 11'h040, 11'h7F0};
  logic [7:0]  cmd_code, page;
  logic        wr_stb, rd_stb, rd_valid, nack, cml_flag, invalid_data, invalid_command_fault, smb_alert_n;
  logic [15:0] exp_q[$];
  int          bad_count = 0, comparisons = 0;
  always #4 clk = ~clk;
  pvg_host host_u (.*);
  pvg_regs dut_u (.*);
  always @(negedge clk)
    if (rd_valid)
    begin
      `CHK(exp_q.size() > 0, 1'b1)
      exp_v = exp_q.pop_front();
      `CHK(rd_word, exp_v)
    end
  task automatic wr(input logic [7:0] c, p, input logic [15:0] w);
    host_u.xfer(1'b1, c, p, w, $urandom_range(2));
  endtask
  task automatic rd(input logic [7:0] c, p, input logic [15:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, c, p, 16'h0000, 0);
  endtask
  task automatic flags(input logic [3:0] e);
    `CHK({cml_flag, invalid_data, invalid_command_fault, smb_alert_n}, e)
    status_clr = 1;
    @(posedge clk) #1 status_clr = 0;
  endtask
  task automatic do_reset(input logic ul);
    nrst = 0;
    user_load = ul;
    repeat (2) @(posedge clk);
    #1 nrst = 1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h2f38f6b8));
    do_reset(0);
    rd(TH, 8'h00, 16'hF010);
    rd(GN, 8'h01, 16'h8020);
    $display("reset values done");
    m = 11'h010 + 11'($urandom_range(21));
    wr(TH, 8'h00, {5'h1F, m});
    rd(TH, 8'h00, {PVG_THR_EXP, m});
    wr(TH, 8'h00, 16'hF026);
    rd(TH, 8'h00, 16'hF025);
    wr(TH, 8'h00, 16'hF034);
    rd(TH, 8'h00, 16'hF033);
    foreach (bad[i])
    begin
      wr(TH, 8'h00, {PVG_THR_EXP, bad[i]});
      flags(4'b1100);
    end
    rd(TH, 8'h00, 16'hF033);
    input_turn_on_threshold = 16'hF014;
    wr(TH, 8'h00, 16'hF014);
    flags(4'b1100);
    wr(TH, 8'h00, 16'hF013);
    rd(TH, 8'h00, 16'hF013);
    `CHK(thr_word, 16'hF013)
    $display("threshold done");
    wr(GN, 8'h00, 16'h01FC);
    rd(GN, 8'h00, {PVG_GAIN_EXP, 11'h1FC});
    wr(GN, 8'h00, 16'h81FD);
    flags(4'b1100);
    wr(GN, 8'h01, 16'h8010);
    rd(GN, 8'h01, 16'h8010);
    wr(GN, 8'hFF, 16'h8064);
    rd(GN, 8'h00, 16'h8064);
    rd(GN, 8'h01, 16'h8064);
    ch2_master = 0;
    wr(GN, 8'h01, 16'h80C8);
    `CHK(nack, 1'b1)
    flags(4'b1010);
    wr(GN, 8'h00, 16'h8040);
    @(posedge clk) #1 `CHK(gain2_word, 16'h8040)
    `CHK(gain1_word, 16'h8040)
    $display("gain done");
    ch2_master = 1;
    do_reset(1);
    rd(TH, 8'h00, {PVG_THR_EXP, user_thr_mant});
    rd(GN, 8'h01, {PVG_GAIN_EXP, user_gain2_mant});
    $display("user defaults done");
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk);
    if (exp_q.size() > 0) bad_count++;
    finish_test();
  end
endmodule
